// File: rtl/pts_supervisor.sv
// Purpose: trigger acceptance, encoder count, fault state and lamp control
// Assumes: single 250 MHz clock, async active-low reset, APB slave
// Notes:   trigger and encoder pins pass a two-stage synchroniser
`timescale 1ns/10ps
module pts_supervisor
  import pts_pkg::*;
#(
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC,
  parameter int unsigned ENC_W     = 32
)(
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // external pins
  input  wire logic              LINE_TRIG,
  input  wire logic              ENC_IN,
  input  wire logic              OVERHEAT,
  // sensor handshake
  input  wire logic              SENSOR_BUSY,
  output logic                   ACQ_START,
  output logic                   LINE_TAG,
  // status outputs
  output logic      [1:0]        STATUS_LAMP,
  output logic                   RESTART,
  output logic                   IRQ
);

  // ********************************************************************
  // input synchronisers
  // ********************************************************************
  logic [2:0] sy1_q, sy2_q;
  logic       trig_prev_q, enc_prev_q;

  // two flops per pin before any logic reads it
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
    begin
      sy1_q <= 3'h0;
      sy2_q <= 3'h0;
      trig_prev_q <= 1'b0;
      enc_prev_q <= 1'b0;
    end
    else
    begin
      sy1_q <= {OVERHEAT, ENC_IN, LINE_TRIG};
      sy2_q <= sy1_q;
      trig_prev_q <= sy2_q[0];
      enc_prev_q <= sy2_q[1];
    end

  logic trig_edge, enc_edge, hot;
  assign trig_edge = sy2_q[0] & ~trig_prev_q;
  assign enc_edge  = sy2_q[1] & ~enc_prev_q;
  assign hot       = sy2_q[2];

  // ********************************************************************
  // apb decode
  // ********************************************************************
  pts_apb_req_t req;
  logic         wr, rd_ok;
  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  assign wr  = req.sel & req.enable & req.write & PREADY;

  logic ctrl_wr, fw_start, fw_done, fw_bad, enc_clr;
  assign ctrl_wr  = wr && (req.addr == OFS_CTRL);
  assign enc_clr  = ctrl_wr && req.wdata[CTRL_ENC_CLR];
  assign fw_start = ctrl_wr && req.wdata[CTRL_FW_START];
  assign fw_done  = ctrl_wr && req.wdata[CTRL_FW_DONE];
  assign fw_bad   = ctrl_wr && req.wdata[CTRL_FW_BAD];

  // ********************************************************************
  // fault and update state
  // ********************************************************************
  typedef enum logic [1:0] {ST_RUN, ST_FAULT, ST_UPDATE, ST_BOOT} pts_state_t;
  pts_state_t st_q;
  logic       scan_en_q;
  logic [4:0] boot_cnt_q;

  // fault entry, update and self restart
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
    begin
      st_q <= ST_RUN;
      boot_cnt_q <= 5'h0;
    end
    else
    begin
      case (st_q)
        ST_RUN:
          if (fw_start)
            st_q <= ST_UPDATE;
          else if (fw_bad || hot)
            st_q <= ST_FAULT;
        ST_FAULT:
          if (fw_start)
            st_q <= ST_UPDATE;  // only an update start leaves fault
        ST_UPDATE:
          if (fw_done)
          begin
            st_q <= ST_BOOT;
            boot_cnt_q <= 5'h0;
          end
        ST_BOOT:
          if (boot_cnt_q == 5'(REBOOT_CYC - 1))
            st_q <= ST_RUN;  // restart after update
          else
            boot_cnt_q <= boot_cnt_q + 5'h1;
        default:
          st_q <= ST_RUN;
      endcase
    end

  logic acq_allowed;
  assign acq_allowed = (st_q == ST_RUN) && scan_en_q;

  // ********************************************************************
  // trigger acceptance
  // ********************************************************************
  logic pend_q, busy, miss_ev;
  logic [15:0] miss_cnt_q;

  // start now if ready, else hold one pending flag
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
    begin
      pend_q <= 1'b0;
      ACQ_START <= 1'b0;
      LINE_TAG <= 1'b0;
    end
    else
    begin
      ACQ_START <= 1'b0;
      if (!acq_allowed)
        pend_q <= 1'b0;  // no acquisition in fault
      else if (!SENSOR_BUSY && !ACQ_START && (pend_q || trig_edge))
      begin
        ACQ_START <= 1'b1;  // immediate or pending start when ready
        pend_q <= 1'b0;
        LINE_TAG <= ~LINE_TAG;  // one image per frame line
      end
      else if (trig_edge)
        pend_q <= 1'b1;
    end

  // a trigger while busy or with one already pending is a miss; extra ones are dropped
  assign busy    = SENSOR_BUSY | ACQ_START | pend_q;
  assign miss_ev = acq_allowed && trig_edge && busy;

  // ********************************************************************
  // warning and detail info
  // ********************************************************************
  logic [4:0]  info_cnt_q;
  logic        info_arm_q, info_ev;
  logic [15:0] info_q;

  // schedule the detail message after the warning
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
    begin
      miss_cnt_q <= 16'h0;
      info_arm_q <= 1'b0;
      info_cnt_q <= 5'h0;
      info_q <= 16'h0;
    end
    else
    begin
      if (miss_ev)
      begin
        miss_cnt_q <= miss_cnt_q + 16'h1;
        info_arm_q <= 1'b1;
        info_cnt_q <= 5'h0;
      end
      else if (info_arm_q)
      begin
        if (info_cnt_q == 5'(INFO_DELAY_CYC - 1))
        begin
          info_arm_q <= 1'b0;
          info_q <= miss_cnt_q;  // detail: total misses
        end
        else
          info_cnt_q <= info_cnt_q + 5'h1;
      end
    end
  assign info_ev = info_arm_q && !miss_ev && (info_cnt_q == 5'(INFO_DELAY_CYC - 1));

  // ********************************************************************
  // encoder counter
  // ********************************************************************
  logic [ENC_W-1:0] enc_q;

  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
      enc_q <= '0;
    else if (enc_clr)
      enc_q <= '0;
    else if (enc_edge)
      enc_q <= enc_q + 1'b1;

  // ********************************************************************
  // interrupts
  // ********************************************************************
  logic [IRQ_W-1:0] irq_st_q, irq_mk_q, irq_set, irq_clr;
  // fault flag only when the state really moves to fault, not to update
  assign irq_set = {(st_q == ST_RUN) && !fw_start && (fw_bad || hot), info_ev, miss_ev};
  assign irq_clr = (wr && req.addr == OFS_IRQ_ST) ? req.wdata[IRQ_W-1:0] : '0;

  // sticky bits, set wins over clear
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
    begin
      irq_st_q <= IRQ_RST;
      irq_mk_q <= IRQ_RST;
      scan_en_q <= 1'b0;
      IRQ <= 1'b0;
    end
    else
    begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
      if (wr && req.addr == OFS_IRQ_MK)
        irq_mk_q <= req.wdata[IRQ_W-1:0];
      if (ctrl_wr)
        scan_en_q <= req.wdata[CTRL_SCAN_EN];
      IRQ <= |(irq_st_q & irq_mk_q);
    end

  // ********************************************************************
  // status lamp and restart
  // ********************************************************************
  logic [31:0] blink_q;
  logic        blink_ph_q;

  // fast blink divider and lamp colour
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
    begin
      blink_q <= 32'h0;
      blink_ph_q <= 1'b0;
      STATUS_LAMP <= LAMP_OFF;
      RESTART <= 1'b0;
    end
    else
    begin
      if (blink_q >= 32'(BLINK_CYC - 1))
      begin
        blink_q <= 32'h0;
        blink_ph_q <= ~blink_ph_q;
      end
      else
        blink_q <= blink_q + 32'h1;
      RESTART <= (st_q == ST_BOOT);
      case (st_q)
        ST_FAULT:  STATUS_LAMP <= LAMP_RED;
        ST_UPDATE: STATUS_LAMP <= blink_ph_q ? LAMP_YELLOW : LAMP_OFF;
        ST_BOOT:   STATUS_LAMP <= LAMP_OFF;
        default:   STATUS_LAMP <= LAMP_GREEN;
      endcase
    end

  // ********************************************************************
  // apb read and answer
  // ********************************************************************
  logic [31:0] rdata;
  logic        hit;

  always_comb
  begin
    rdata = 32'h0;
    hit = 1'b1;
    case (req.addr)
      OFS_CTRL:   rdata = {27'h0, scan_en_q, 4'h0};
      OFS_STATUS: rdata = {28'h0, pend_q, SENSOR_BUSY, st_q};
      OFS_IRQ_ST: rdata = {29'h0, irq_st_q};
      OFS_IRQ_MK: rdata = {29'h0, irq_mk_q};
      OFS_ENC:    rdata = 32'(enc_q);
      OFS_MISS:   rdata = {16'h0, miss_cnt_q};
      OFS_INFO:   rdata = {16'h0, info_q};
      OFS_BUSY:   rdata = 32'h0;
      default:    hit = 1'b0;
    endcase
  end
  assign rd_ok = hit;

  // no wait state: ready in the first access cycle, one cycle high
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= req.sel && !PREADY;
      PRDATA <= rd_ok ? rdata : 32'h0;
      PSLVERR <= req.sel && !PREADY && !rd_ok;
    end

endmodule

// File: rtl/pts_pkg.sv
// Purpose: shared constants and types for the profile trigger supervisor
// Assumes: 250 MHz device clock, APB register access
// Notes:   offsets are byte addresses of 32-bit words
package pts_pkg;

  // ********************************************************************
  // clock and timing
  // ********************************************************************
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned BLINK_HALF_MS  = 100;  // fast yellow blink half period
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int unsigned INFO_DELAY_CYC = 16;   // gap before detail message
  localparam int unsigned REBOOT_CYC     = 16;   // restart pulse length

  // ********************************************************************
  // register offsets
  // ********************************************************************
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_ST = 12'h008;
  localparam logic [11:0] OFS_IRQ_MK = 12'h00c;
  localparam logic [11:0] OFS_ENC    = 12'h010;
  localparam logic [11:0] OFS_MISS   = 12'h014;
  localparam logic [11:0] OFS_INFO   = 12'h018;
  localparam logic [11:0] OFS_BUSY   = 12'h01c;

  // ctrl bit positions
  localparam int CTRL_ENC_CLR  = 0;  // write one: clear encoder count
  localparam int CTRL_FW_START = 1;  // write one: start firmware update
  localparam int CTRL_FW_DONE  = 2;  // write one: new image loaded and valid
  localparam int CTRL_FW_BAD   = 3;  // write one: report firmware fault
  localparam int CTRL_SCAN_EN  = 4;  // level: acquisition enabled

  // interrupt status bit positions
  localparam int IRQ_MISS = 0;  // warning: missed trigger
  localparam int IRQ_INFO = 1;  // info: detail message ready
  localparam int IRQ_FLT  = 2;  // fault state entered
  localparam int IRQ_W    = 3;

  // sticky status reset values
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // lamp colour codes
  typedef enum logic [1:0] {LAMP_OFF, LAMP_GREEN, LAMP_YELLOW, LAMP_RED} pts_lamp_t;

  // apb request bundle
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pts_apb_req_t;

endpackage

// File: tb/pts_sva.sv
// Purpose: port property checks for the trigger supervisor
// Assumes: one clock, async active-low reset
// Notes:   bound to every supervisor instance
`timescale 1ns/10ps
module pts_sva
  import pts_pkg::*;
(
  // clock and reset
  input wire logic       CLOCK,
  input wire logic       RESET_N,
  // apb handshake
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PREADY,
  // pins and status
  input wire logic       OVERHEAT,
  input wire logic       SENSOR_BUSY,
  input wire logic       ACQ_START,
  input wire logic       LINE_TAG,
  input wire logic [1:0] STATUS_LAMP,
  input wire logic       RESTART
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  chk_start_pulse: assert property (ACQ_START |=> !ACQ_START)
    else $error("start pulse too long");
  chk_start_ready: assert property (ACQ_START |-> !$past(SENSOR_BUSY))
    else $error("start while sensor busy");
  chk_tag_step: assert property (ACQ_START |-> LINE_TAG != $past(LINE_TAG))
    else $error("line tag did not step");
  chk_tag_hold: assert property (!ACQ_START |-> $stable(LINE_TAG))
    else $error("line tag moved without start");
  chk_fault_quiet: assert property (
    STATUS_LAMP == LAMP_RED && $past(STATUS_LAMP) == LAMP_RED |-> !ACQ_START)
    else $error("start while in fault");
  chk_red_exit: assert property (
    STATUS_LAMP == LAMP_RED |=> STATUS_LAMP != LAMP_GREEN)
    else $error("fault left without update");
  chk_restart_len: assert property (
    $rose(RESTART) |-> RESTART[*8] ##1 RESTART[*8] ##1 !RESTART)
    else $error("restart length wrong");
  chk_apb_wait: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("apb answer late");
  chk_ready_sel: assert property (PREADY |-> PSEL)
    else $error("ready without select");
  chk_heat_red: assert property (
    $rose(OVERHEAT) && STATUS_LAMP == LAMP_GREEN |-> ##[2:8] STATUS_LAMP == LAMP_RED)
    else $error("overheat did not show red");
endmodule
bind pts_supervisor pts_sva pts_sva_inst (.*);

// File: tb/pts_partner.sv
// Purpose: trigger source, encoder and sensor stand-in
// Assumes: bench asks for pulses no faster than one per six cycles
// Notes:   sensor stays busy for busy_len cycles after each start
`timescale 1ns/10ps
module pts_partner (
  // clock
  input  wire logic CLOCK,
  // requests from the bench
  input  wire logic trig_req,
  input  wire logic enc_req,
  input  wire logic [7:0] busy_len,
  // pins facing the supervisor
  input  wire logic ACQ_START,
  output logic      LINE_TRIG,
  output logic      ENC_IN,
  output logic      SENSOR_BUSY
);
  logic [1:0] trig_q = 2'h0;
  logic [1:0] enc_q  = 2'h0;
  int         busy_q = 0;
  // two-cycle pulses, spaced under max_line_trigger_rate
  always @(posedge CLOCK)
  begin
    trig_q <= trig_req ? 2'h3 : {1'b0, trig_q[1]};
    enc_q  <= enc_req ? 2'h3 : {1'b0, enc_q[1]};
  end
  // sensor turns busy the cycle after a start
  always @(posedge CLOCK)
    busy_q <= ACQ_START ? int'(busy_len) : (busy_q > 0 ? busy_q - 1 : 0);
  assign LINE_TRIG   = trig_q[0];
  assign ENC_IN      = enc_q[0];
  assign SENSOR_BUSY = busy_q > 0;
endmodule

// File: tb/pts_supervisor_tb.sv
// Purpose: self-checking bench for the trigger supervisor
// Assumes: 250 MHz clock, short blink period
// Notes:   expectations come from integer counts of triggers and pulses
`timescale 1ns/10ps
module pts_supervisor_tb
  import pts_pkg::*;
;
  logic        CLOCK = 1'b0, RESET_N, PSEL, PENABLE, PWRITE, OVERHEAT;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        PREADY, PSLVERR, LINE_TRIG, ENC_IN, SENSOR_BUSY, ACQ_START, LINE_TAG;
  logic        RESTART, IRQ, er, trig_req, enc_req, y;
  logic [1:0]  STATUS_LAMP;
  logic [7:0]  busy_len;
  int          err_count = 0, cmp_count = 0, starts = 0, exp_st, exp_miss = 0, n;
  integer      seed;
  int          enc_q[$];
  // ****
  // clock, instances, start counter
  // ****
  always #2 CLOCK = ~CLOCK;
  pts_supervisor #(.BLINK_CYC(4)) pts_supervisor_inst (.*);
  pts_partner pts_partner_inst (.*);
  always @(posedge CLOCK) if (ACQ_START === 1'b1) starts <= starts + 1;
  // ****
  // tasks
  // ****
  task automatic tick(input int k);
    repeat (k) @(posedge CLOCK);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic pulse(input logic t);
    if (t) trig_req <= 1'b1;
    else enc_req <= 1'b1;
    @(posedge CLOCK);
    trig_req <= 1'b0;
    enc_req  <= 1'b0;
    tick(5);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    #100000;
    err_count++;
    complete_run;
  end
  // main sequence
  initial
  begin
    seed = 32'hda58;
    {RESET_N, PSEL, PENABLE, PWRITE, OVERHEAT, trig_req, enc_req} <= '0;
    PADDR    <= '0;
    PWDATA   <= '0;
    busy_len <= 8'h3c;
    tick(12);
    RESET_N <= 1'b1;
    tick(2);
    chk(STATUS_LAMP, LAMP_GREEN);
    apb(1'b1, OFS_CTRL, 32'h10);
    apb(1'b1, OFS_IRQ_MK, 32'h7);
    apb(1'b0, 12'h020, 32'h0);
    chk(er, 1'b1);
    // one start, then three misses folded into one pending start
    pulse(1'b1);
    repeat (3) pulse(1'b1);
    tick(70);
    pulse(1'b1);
    tick(80);
    exp_st = 3;
    exp_miss = 4;
    chk(starts, exp_st);
    chk(IRQ, 1'b1);
    apb(1'b0, OFS_MISS, 32'h0);
    chk(rd, exp_miss);
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(rd[1:0], 2'h3);
    apb(1'b0, OFS_INFO, 32'h0);
    chk(rd, exp_miss);
    apb(1'b1, OFS_IRQ_MK, 32'h0);
    tick(2);
    chk(IRQ, 1'b0);
    apb(1'b1, OFS_IRQ_ST, 32'h7);
    apb(1'b1, OFS_IRQ_MK, 32'h7);
    tick(2);
    chk(IRQ, 1'b0);
    // random number of encoder pulses, then clear
    n = 1 + (($random(seed) & 32'h7fffffff) % 8);
    for (int i = 0; i < n; i++) enc_q.push_back(i);
    repeat (n) pulse(1'b0);
    apb(1'b0, OFS_ENC, 32'h0);
    chk(rd, enc_q.size());
    apb(1'b1, OFS_CTRL, 32'h11);
    enc_q.delete();
    apb(1'b0, OFS_ENC, 32'h0);
    chk(rd, enc_q.size());
    // fault by overheat, then by firmware, each left through an update
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0) OVERHEAT <= 1'b1;
      else apb(1'b1, OFS_CTRL, 32'h18);
      tick(10);
      OVERHEAT <= 1'b0;
      chk(STATUS_LAMP, LAMP_RED);
      n = starts;
      pulse(1'b1);
      tick(4);
      chk(starts, n);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[1:0], 2'h1);
      apb(1'b1, OFS_CTRL, 32'h12);
      y = 1'b0;
      for (int i = 0; i < 12; i++) @(posedge CLOCK) y |= (STATUS_LAMP === LAMP_YELLOW);
      chk(y, 1'b1);
      apb(1'b1, OFS_CTRL, 32'h14);
      for (n = 0; n < 40 && RESTART !== 1'b1; n++) tick(1);
      chk(RESTART, 1'b1);
      tick(30);
      chk(STATUS_LAMP, LAMP_GREEN);
      apb(1'b0, OFS_IRQ_ST, 32'h0);
      chk(rd[2], 1'b1);
      apb(1'b1, OFS_IRQ_ST, 32'h7);
    end
    complete_run;
  end
endmodule
